// ---- common/hsa_pkg.sv ----
// Purpose: constants shared by the hot-swap status/alert logic
// Assumes: 12-bit current results, 8-bit registers
// Notes:   extended register indices as the device decodes them
package hsa_pkg;
    localparam int         HSA_DATA_W        = 8;
    localparam int         HSA_ADC_W         = 12;
    localparam int         HSA_ADDR_W        = 7;
    // extended register addresses
    localparam logic [6:0] HSA_ADDR_ALERT_EN = 7'h01;
    localparam logic [6:0] HSA_ADDR_IRQ_CURRENT_THRESHOLD = 7'h02;
    localparam logic [6:0] HSA_ADDR_CONTROL  = 7'h03;
    // alert-enable fields
    localparam int         HSA_EN_SINGLE     = 0;
    localparam int         HSA_EN_FOUR       = 1;
    localparam int         HSA_EN_HSFAIL     = 2;
    localparam int         HSA_EN_OFF        = 3;
    localparam int         HSA_EN_CLEAR      = 4;
    localparam int         HSA_EN_W          = 4;
    localparam logic [3:0] HSA_EN_RESET      = 4'h4;
    // control fields
    localparam int         HSA_CTL_SOFTWARE_SHUTDOWN     = 0;
    // threshold reset: adc full scale
    localparam logic [7:0] HSA_TH_RESET      = 8'hFF;
    // status bits
    localparam int         HSA_ST_ADC_LIVE   = 0;
    localparam int         HSA_ST_ADC_ALERT  = 1;
    localparam int         HSA_ST_AOC_OFF    = 2;
    localparam int         HSA_ST_HS_FAIL    = 3;
    localparam int         HSA_ST_OFF        = 4;
    localparam int         HSA_ST_OFF_ALERT  = 5;
    // conversion history depths
    localparam int         HSA_LIVE_DEPTH    = 3;
    localparam int         HSA_FOUR_DEPTH    = 4;
    localparam int         HSA_HIST_W        = 4;
endpackage

// ---- common/hsa_cmp_if.sv ----
// Purpose: carries conversion results and trip decisions between modules
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
interface hsa_cmp_if;
    logic        conv_valid;
    logic [11:0] conv_current;
    logic [7:0]  threshold;
    logic        live_trip;
    logic        single_trip;
    logic        four_trip;
    modport tracker (
        input  conv_valid, conv_current, threshold,
        output live_trip, single_trip, four_trip
    );
    modport user (
        output conv_valid, conv_current, threshold,
        input  live_trip, single_trip, four_trip
    );
endinterface
`default_nettype wire

// ---- logic/hsa_conv_tracker.sv ----
// Purpose: tracks over-threshold history of current conversions
// Assumes: conv_valid pulses once per finished conversion
// Notes:   trips are registered, one cycle after conv_valid
`timescale 1ns/100ps
`default_nettype none
module hsa_conv_tracker
    import hsa_pkg::*;
(
    // clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    // comparison channel
    hsa_cmp_if.tracker    cmp
);
    logic [HSA_HIST_W-1:0] hist_reg;
    logic [HSA_HIST_W-1:0] hist_next;
    logic                  over;

    // upper eight bits of the result against the threshold
    assign over = cmp.conv_current[HSA_ADC_W-1 -: HSA_DATA_W] > cmp.threshold;
    assign hist_next = {hist_reg[HSA_HIST_W-2:0], over};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg <= '0;
        end else if (cmp.conv_valid) begin
            hist_reg <= hist_next;
        end
    end

    // live flag: last three conversions all over
    assign cmp.live_trip   = &hist_reg[HSA_LIVE_DEPTH-1:0];
    assign cmp.single_trip = hist_reg[0];
    // four consecutive conversions over
    assign cmp.four_trip   = &hist_reg[HSA_FOUR_DEPTH-1:0];
endmodule
`default_nettype wire

// ---- logic/hsa_status_alert.sv ----
// Purpose: status byte, alert enables and open-drain alert of a hot-swap
//          controller
// Assumes: register writes arrive as one-cycle strobes from the serial
//          front end; status is read as a byte
// Notes:   latch-off or auto-retry reporting of the analog over-current status bit chosen by a parameter
`timescale 1ns/100ps
`default_nettype none
module hsa_status_alert
    import hsa_pkg::*;
#(
    parameter bit LATCH_OFF = 1'b1
)
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // register writes from the serial front end
    input  wire logic                  reg_wr,
    input  wire logic [HSA_ADDR_W-1:0] reg_addr,
    input  wire logic [HSA_DATA_W-1:0] reg_wdata,
    // conversion results
    input  wire logic                  conv_valid,
    input  wire logic [HSA_ADC_W-1:0]  conv_current,
    // hot-swap core
    input  wire logic                  on_pin,
    input  wire logic                  analog_oc_off,
    input  wire logic                  hotswap_fail,
    output logic                       hotswap_force_off,
    // register read back
    output logic [HSA_DATA_W-1:0]      alert_status_byte,
    output logic [HSA_DATA_W-1:0]      alert_enable_byte,
    output logic [HSA_DATA_W-1:0]      irq_current_threshold,
    // open-drain alert pin
    output logic                       irq_out_n_o,
    output logic                       irq_out_n_oe_n
);
    import hsa_pkg::*;

    logic [HSA_EN_W-1:0]   en_reg;
    logic [HSA_DATA_W-1:0] th_reg;
    logic                  software_shutdown;
    logic                  clear_req;
    logic                  adc_alert_reg;
    logic                  hotswap_fail_latched;
    logic                  off_alert_reg;
    logic                  off_prev_reg;
    logic                  adc_overcurrent_live;
    logic                  analog_overcurrent_off;
    logic                  off_state;
    logic                  adc_trip;
    logic                  off_rise;
    logic                  alert_next;
    logic [HSA_DATA_W-1:0] status_next;

    hsa_cmp_if cmp ();

    function automatic logic wr_hit(input logic [HSA_ADDR_W-1:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    assign cmp.conv_valid   = conv_valid;
    assign cmp.conv_current = conv_current;
    assign cmp.threshold    = th_reg;

    hsa_conv_tracker u_tracker (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cmp     (cmp)
    );

    // enables; clear is a one-cycle pulse, never stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= HSA_EN_RESET;
        end else if (wr_hit(HSA_ADDR_ALERT_EN)) begin
            en_reg <= reg_wdata[HSA_EN_W-1:0];
        end
    end
    assign clear_req = wr_hit(HSA_ADDR_ALERT_EN) && reg_wdata[HSA_EN_CLEAR];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            th_reg <= HSA_TH_RESET;
        end else if (wr_hit(HSA_ADDR_IRQ_CURRENT_THRESHOLD)) begin
            th_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            software_shutdown <= 1'b0;
        end else if (wr_hit(HSA_ADDR_CONTROL)) begin
            software_shutdown <= reg_wdata[HSA_CTL_SOFTWARE_SHUTDOWN];
        end
    end

    // software off acts just like the on-input going low
    assign off_state = !on_pin || software_shutdown;
    assign adc_overcurrent_live = cmp.live_trip;
    assign adc_trip = (en_reg[HSA_EN_SINGLE] && cmp.single_trip)
                   || (en_reg[HSA_EN_FOUR] && cmp.four_trip);
    assign off_rise = off_state && !off_prev_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_prev_reg <= 1'b0;
        end else begin
            off_prev_reg <= off_state;
        end
    end

    // latched flags: a set in the clear cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_alert_reg <= 1'b0;
        end else if (adc_trip) begin
            adc_alert_reg <= 1'b1;
        end else if (clear_req) begin
            adc_alert_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hotswap_fail_latched <= 1'b0;
        end else if (hotswap_fail && en_reg[HSA_EN_HSFAIL]) begin
            hotswap_fail_latched <= 1'b1;
        end else if (clear_req) begin
            hotswap_fail_latched <= 1'b0;
        end
    end

    // edge-caused so a held-off pin does not re-set after clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_alert_reg <= 1'b0;
        end else if (off_rise && en_reg[HSA_EN_OFF]) begin
            off_alert_reg <= 1'b1;
        end else if (clear_req) begin
            off_alert_reg <= 1'b0;
        end
    end

    // latch-off parts with the fail enable set mirror the fail flag; others show live state
    assign analog_overcurrent_off = (LATCH_OFF && en_reg[HSA_EN_HSFAIL])
                                  ? hotswap_fail_latched
                                  : analog_oc_off;

    // reading has no side effect; top bits zero
    always_comb begin
        status_next = '0;
        status_next[HSA_ST_ADC_LIVE]  = adc_overcurrent_live;
        status_next[HSA_ST_ADC_ALERT] = adc_alert_reg;
        status_next[HSA_ST_AOC_OFF]   = analog_overcurrent_off;
        status_next[HSA_ST_HS_FAIL]   = hotswap_fail_latched;
        status_next[HSA_ST_OFF]       = off_state;
        status_next[HSA_ST_OFF_ALERT] = off_alert_reg;
    end

    // flags only set through enabled sources, so reset is silent
    assign alert_next = adc_alert_reg || hotswap_fail_latched || off_alert_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_status_byte     <= '0;
            alert_enable_byte     <= '0;
            irq_current_threshold <= HSA_TH_RESET;
            hotswap_force_off     <= 1'b0;
        end else begin
            alert_status_byte     <= status_next;
            alert_enable_byte     <= {{(HSA_DATA_W-HSA_EN_W){1'b0}}, en_reg};
            irq_current_threshold <= th_reg;
            hotswap_force_off     <= off_state;
        end
    end

    // open drain: output always low, enable low pulls the pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_n_o    <= 1'b0;
            irq_out_n_oe_n <= 1'b1;
        end else begin
            irq_out_n_o    <= 1'b0;
            irq_out_n_oe_n <= !alert_next;
        end
    end
endmodule
`default_nettype wire

// ---- verification/hsa_status_alert_properties.sv ----
// Purpose: port-level checks of the status/alert block
// Assumes: enables held steady around trips
// Notes:   bound to every instance
`timescale 1ns/100ps
`default_nettype none
module hsa_status_alert_properties
    import hsa_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // watched inputs
    input wire logic       reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       hotswap_fail,
    // watched outputs
    input wire logic       hotswap_force_off,
    input wire logic [7:0] alert_status_byte,
    input wire logic [7:0] alert_enable_byte,
    input wire logic [7:0] irq_current_threshold,
    input wire logic       irq_out_n_o,
    input wire logic       irq_out_n_oe_n
);
    wire [7:0] st = alert_status_byte;
    wire       clr_wr = reg_wr && reg_addr == HSA_ADDR_ALERT_EN
                     && reg_wdata[HSA_EN_CLEAR];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_pad_low: assert property (irq_out_n_o == 1'b0)
        else $error("alert pad drives high");
    a_top_zero: assert property (st[7:6] == 2'h0)
        else $error("status top bits set");
    a_irq_flags: assert property (
        irq_out_n_oe_n == !(st[1] || st[3] || st[5]))
        else $error("alert pad disagrees with flags");
    a_off_same: assert property (st[4] == hotswap_force_off)
        else $error("off status disagrees with force off");
    a_th_reset: assert property (
        $rose(rst_n) |-> irq_current_threshold == 8'hFF)
        else $error("threshold not full scale after reset");
    // enable byte lags the enable register by one edge, status by two
    a_fail_latch: assert property (
        hotswap_fail ##1 (alert_enable_byte[2] && !clr_wr) |-> ##1 st[3])
        else $error("hot swap failure not latched");
    a_clear_only: assert property ($fell(st[1]) || $fell(st[3]) || $fell(st[5])
        |-> $past(clr_wr, 2))
        else $error("latched flag fell without clear");
    a_off_alert: assert property ($rose(st[4]) && alert_enable_byte[3]
        |-> ##[0:1] st[5])
        else $error("off alert not latched");
endmodule
bind hsa_status_alert hsa_status_alert_properties u_props (.sys_clk, .rst_n,
    .reg_wr, .reg_addr, .reg_wdata, .hotswap_fail, .hotswap_force_off,
    .alert_status_byte, .alert_enable_byte, .irq_current_threshold,
    .irq_out_n_o, .irq_out_n_oe_n);
`default_nettype wire

// ---- verification/hsa_host_model.sv ----
// Purpose: host side: register writes and pulled-up alert line
// Assumes: writes launched at the falling edge
// Notes:   idle bus shows inverted values, not the last ones
`timescale 1ns/100ps
`default_nettype none
module hsa_host_model (
    // clock
    input  wire logic       sys_clk,
    // register writes
    output var  logic       reg_wr,
    output var  logic [6:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    // alert pad
    input  wire logic       irq_out_n_o,
    input  wire logic       irq_out_n_oe_n,
    output wire logic       irq_line
);
    // released pad floats to the pull-up
    assign irq_line = irq_out_n_oe_n ? 1'b1 : irq_out_n_o;
    initial begin
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- verification/hotswap_status_alert_tb_top.sv ----
// Purpose: self-checking bench for the status/alert block
// Assumes: latch-off and retry variants side by side
// Notes:   inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module hotswap_status_alert_tb_top;
    import hsa_pkg::*;
    localparam logic [6:0] A_EN = HSA_ADDR_ALERT_EN;
    localparam logic [6:0] A_TH = HSA_ADDR_IRQ_CURRENT_THRESHOLD;
    localparam logic [6:0] A_CT = HSA_ADDR_CONTROL;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        conv_valid = 1'b0;
    logic [11:0] conv_current = 12'h000;
    logic        on_pin = 1'b1;
    logic        aoc = 1'b0;
    logic        fail = 1'b0;
    logic        reg_wr;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata, st, en, th;
    logic        off, pad_o, pad_oe_n, irq;
    logic [7:0]  st_r;
    int          num_errors = 0;
    int          n_checks = 0;
    always #4 sys_clk = ~sys_clk;
    hsa_status_alert u_dut (.sys_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata,
        .conv_valid, .conv_current, .on_pin, .analog_oc_off(aoc),
        .hotswap_fail(fail), .hotswap_force_off(off), .alert_status_byte(st),
        .alert_enable_byte(en), .irq_current_threshold(th),
        .irq_out_n_o(pad_o), .irq_out_n_oe_n(pad_oe_n));
    hsa_host_model u_host (.sys_clk, .reg_wr, .reg_addr, .reg_wdata,
        .irq_out_n_o(pad_o), .irq_out_n_oe_n(pad_oe_n), .irq_line(irq));
    // retry variant shares all stimulus; only its status is judged
    hsa_status_alert #(.LATCH_OFF(1'b0)) u_dut_retry (.sys_clk, .rst_n,
        .reg_wr, .reg_addr, .reg_wdata, .conv_valid, .conv_current, .on_pin,
        .analog_oc_off(aoc), .hotswap_fail(fail), .hotswap_force_off(),
        .alert_status_byte(st_r), .alert_enable_byte(),
        .irq_current_threshold(), .irq_out_n_o(), .irq_out_n_oe_n());
    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cv(input logic [11:0] v, input int n);
        repeat (n) begin
            @(negedge sys_clk);
            conv_valid = 1'b1;
            conv_current = v;
            @(negedge sys_clk);
            conv_valid = 1'b0;
            conv_current = ~v;
            repeat (3) @(negedge sys_clk);
        end
    endtask
    task automatic t_reset;
        chk("status", 8'h00, st);
        chk("enable", 8'h04, en);
        chk("threshold", 8'hFF, th);
        chk("alert", 8'h01, {7'h00, irq});
    endtask
    task automatic t_off;
        u_host.wr(A_EN, 8'h08);
        u_host.wr(A_CT, 8'h01);
        chk("status", 8'h30, st);
        chk("force off", 8'h01, {7'h00, off});
        chk("alert", 8'h00, {7'h00, irq});
        u_host.wr(A_EN, 8'h18);
        chk("status", 8'h10, st);
        u_host.wr(A_CT, 8'h00);
        on_pin = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("status", 8'h30, st);
        on_pin = 1'b1;
        u_host.wr(A_EN, 8'h10);
        chk("status", 8'h00, st);
        chk("alert", 8'h01, {7'h00, irq});
    endtask
    task automatic t_adc;
        u_host.wr(A_TH, 8'h80);
        u_host.wr(A_EN, 8'h01);
        chk("threshold", 8'h80, th);
        cv(12'h80F, 1);
        chk("status", 8'h00, st);
        cv(12'h810, 1);
        chk("status", 8'h02, st);
        cv(12'h810, 2);
        chk("status", 8'h03, st);
        cv(12'h000, 1);
        chk("status", 8'h02, st);
        u_host.wr(A_EN, 8'h10);
        chk("status", 8'h00, st);
    endtask
    task automatic t_four;
        u_host.wr(A_EN, 8'h02);
        cv(12'h810, 3);
        chk("status", 8'h01, st);
        cv(12'h810, 1);
        chk("status", 8'h03, st);
        cv(12'h000, 1);
        u_host.wr(A_EN, 8'h10);
        chk("status", 8'h00, st);
    endtask
    task automatic t_fail;
        u_host.wr(A_EN, 8'h04);
        fail = 1'b1;
        @(negedge sys_clk);
        fail = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("status", 8'h0C, st);
        chk("retry status", 8'h08, st_r);
        u_host.wr(A_EN, 8'h10);
        aoc = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("status", 8'h04, st);
        chk("alert", 8'h01, {7'h00, irq});
        u_host.wr(A_EN, 8'h04);
        chk("status", 8'h00, st);
        chk("retry status", 8'h04, st_r);
        aoc = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("retry status", 8'h00, st_r);
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_off();
        t_adc();
        t_four();
        t_fail();
        results();
    end
    initial begin
        #200000;
        num_errors++;
        $display("unexpected run time exp done got hang");
        results();
    end
endmodule
`default_nettype wire
